// ==== sfe_front_end.v ====
// Purpose: serial command front end of a quad-capable serial flash
// Assumes: sel_n, sck, si synchronous to sys_clk, sck at most a quarter of sys_clk
// Notes:   array bytes are prefetched into a fifo; the shifter drains it per byte
`include "sfe_defines.vh"

module sfe_front_end (
    input  wire        sys_clk,
    input  wire        nrst,
    input  wire        sel_n,
    input  wire        sck,
    input  wire        si,
    input  wire [2:0]  density_sel,
    input  wire        write_in_progress,
    input  wire        write_latch,
    input  wire        quad_enable,
    input  wire        fetch_ack,
    input  wire [7:0]  fetch_data,
    output reg         so_out_q,
    output reg         so_oe_q,
    output reg         fetch_req_q,
    output reg  [18:0] fetch_addr_q,
    output reg  [7:0]  instr_q,
    output reg  [4:0]  cmd_class_q,
    output reg         cmd_go_q,
    output reg         read_refused_q,
    output reg         quad_lines_q
);
    localparam [2:0] ST_OPCODE = 3'h0;
    localparam [2:0] ST_ADDR   = 3'h1;
    localparam [2:0] ST_DATA   = 3'h2;
    localparam [2:0] ST_ARGS   = 3'h3;
    localparam [2:0] ST_IGNORE = 3'h4;

    // decoded address mask per density
    function [18:0] dens_mask;
        input [2:0] dens;
        begin
            case (dens)
                `SFE_DENS_4M:   dens_mask = 19'h7ffff;
                `SFE_DENS_2M:   dens_mask = 19'h3ffff;
                `SFE_DENS_1M:   dens_mask = 19'h1ffff;
                `SFE_DENS_512K: dens_mask = 19'h0ffff;
                default:        dens_mask = 19'h07fff;
            endcase
        end
    endfunction

    // opcode to class; the byte decides, and density also decides erase all
    function [4:0] classify;
        input [7:0] op;
        input [2:0] dens;
        begin
            case (op)
                `SFE_OP_READ:            classify = `SFE_CLS_READ;
                `SFE_OP_FAST_READ:       classify = `SFE_CLS_FAST_READ;
                `SFE_OP_DUAL_IO_READ:    classify = `SFE_CLS_DUAL_IO_READ;
                `SFE_OP_DUAL_OUT_READ:   classify = `SFE_CLS_DUAL_OUT_READ;
                `SFE_OP_QUAD_IO_READ:    classify = `SFE_CLS_QUAD_IO_READ;
                `SFE_OP_QUAD_OUT_READ:   classify = `SFE_CLS_QUAD_OUT_READ;
                `SFE_OP_PAGE_PROGRAM:    classify = `SFE_CLS_PAGE_PROGRAM;
                `SFE_OP_QUAD_PP_A,
                `SFE_OP_QUAD_PP_B:       classify = `SFE_CLS_QUAD_PP;
                `SFE_OP_ERASE_ALL_A,
                `SFE_OP_ERASE_ALL_B:     classify = (dens >= `SFE_DENS_256K) ?
                                             `SFE_CLS_NONE : `SFE_CLS_ERASE_ALL;
                `SFE_OP_SUSPEND_A,
                `SFE_OP_SUSPEND_B:       classify = `SFE_CLS_SUSPEND;
                `SFE_OP_RESUME_A,
                `SFE_OP_RESUME_B:        classify = `SFE_CLS_RESUME;
                `SFE_OP_SLEEP_ENTER:     classify = `SFE_CLS_SLEEP_ENTER;
                `SFE_OP_ID_WAKE:         classify = `SFE_CLS_ID_WAKE;
                `SFE_OP_UNIQUE_ID:       classify = `SFE_CLS_UNIQUE_ID;
                `SFE_OP_STANDARD_ID:     classify = `SFE_CLS_STANDARD_ID;
                `SFE_OP_MAKER_DEV_ID:    classify = `SFE_CLS_MAKER_DEV_ID;
                `SFE_OP_WRITE_LATCH_SET: classify = `SFE_CLS_WRITE_LATCH;
                default:                 classify = `SFE_CLS_NONE;
            endcase
        end
    endfunction

    function is_read_cls;
        input [4:0] cls;
        begin
            is_read_cls = (cls >= `SFE_CLS_READ) && (cls <= `SFE_CLS_QUAD_OUT_READ);
        end
    endfunction

    function is_write_cls;
        input [4:0] cls;
        begin
            is_write_cls = (cls == `SFE_CLS_PAGE_PROGRAM) || (cls == `SFE_CLS_QUAD_PP) ||
                           (cls == `SFE_CLS_ERASE_ALL);
        end
    endfunction

    reg  [2:0]  state_q;
    reg         sck_q;
    reg         sck_prev_q;
    reg         si_q;
    reg         sel_n_q;
    reg  [4:0]  bit_cnt_q;
    reg  [23:0] shift_in_q;
    reg  [7:0]  shift_out_q;
    reg         fetch_on_q;
    reg  [4:0]  held_cls_q;

    wire        sck_rise;
    wire        sck_fall;
    wire [7:0]  op_next;
    wire [4:0]  op_cls;
    wire [23:0] addr_next;
    wire [18:0] mask;
    wire        push;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [7:0]  fifo_out_data;
    wire [4:0]  fifo_level;
    wire        pop;
    wire        flush;

    assign sck_rise  = sck_q & ~sck_prev_q & ~sel_n_q;
    assign sck_fall  = ~sck_q & sck_prev_q & ~sel_n_q;
    assign op_next   = {shift_in_q[6:0], si_q};
    assign op_cls    = classify(op_next, density_sel);
    assign addr_next = {shift_in_q[22:0], si_q};
    assign mask      = dens_mask(density_sel);
    assign push      = fetch_req_q & fetch_ack & fifo_in_ready;
    assign pop       = (state_q == ST_DATA) && sck_fall && (bit_cnt_q == 5'h00);
    assign flush     = sel_n_q;

    sfe_fifo #(
        .WIDTH (`SFE_FIFO_W),
        .DEPTH (`SFE_FIFO_DEPTH),
        .AW    (`SFE_FIFO_AW)
    ) u_fifo (
        .clk       (sys_clk),
        .nrst      (nrst),
        .flush     (flush),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (fetch_data),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    // pin sampling; inputs already synchronous so one stage is enough
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sck_q        <= 1'b0;
            sck_prev_q   <= 1'b0;
            si_q         <= 1'b0;
            sel_n_q      <= 1'b1;
            quad_lines_q <= 1'b0;
        end else begin
            sck_q        <= sck;
            sck_prev_q   <= sck_q;
            si_q         <= si;
            sel_n_q      <= sel_n;
            quad_lines_q <= quad_enable;
        end
    end

    // command sequencer
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q        <= ST_OPCODE;
            bit_cnt_q      <= 5'h00;
            shift_in_q     <= 24'h000000;
            instr_q        <= 8'h00;
            cmd_class_q    <= `SFE_CLS_NONE;
            cmd_go_q       <= 1'b0;
            read_refused_q <= 1'b0;
            held_cls_q     <= `SFE_CLS_NONE;
            fetch_on_q     <= 1'b0;
        end else begin
            cmd_go_q       <= 1'b0;
            read_refused_q <= 1'b0;
            if (sel_n_q) begin
                // deselect ends any sequence; held writes launch here when write_latch is set
                if (is_write_cls(held_cls_q) && write_latch) begin
                    cmd_class_q <= held_cls_q;
                    cmd_go_q    <= 1'b1;
                end
                held_cls_q <= `SFE_CLS_NONE;
                state_q    <= ST_OPCODE;
                bit_cnt_q  <= 5'h00;
                fetch_on_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_OPCODE: begin
                        if (sck_rise) begin
                            shift_in_q <= {16'h0000, op_next};
                            if (bit_cnt_q == 5'd7) begin
                                bit_cnt_q <= 5'h00;
                                instr_q   <= op_next;
                                if (op_cls == `SFE_CLS_NONE) begin
                                    state_q <= ST_IGNORE;
                                end else if (is_read_cls(op_cls) && write_in_progress) begin
                                    read_refused_q <= 1'b1;
                                    state_q        <= ST_IGNORE;
                                end else if (op_cls == `SFE_CLS_READ) begin
                                    cmd_class_q <= op_cls;
                                    cmd_go_q    <= 1'b1;
                                    state_q     <= ST_ADDR;
                                end else if (is_write_cls(op_cls)) begin
                                    held_cls_q <= op_cls;
                                    state_q    <= ST_ARGS;
                                end else begin
                                    cmd_class_q <= op_cls;
                                    cmd_go_q    <= 1'b1;
                                    state_q     <= ST_ARGS;
                                end
                            end else begin
                                bit_cnt_q <= bit_cnt_q + 5'h01;
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (sck_rise) begin
                            shift_in_q <= addr_next;
                            if (bit_cnt_q == 5'd23) begin
                                bit_cnt_q  <= 5'h00;
                                fetch_on_q <= 1'b1;
                                state_q    <= ST_DATA;
                            end else begin
                                bit_cnt_q <= bit_cnt_q + 5'h01;
                            end
                        end
                    end
                    ST_DATA: begin
                        // si is no longer looked at
                        if (sck_fall) begin
                            bit_cnt_q <= {2'b00, bit_cnt_q[2:0] + 3'h1};
                        end
                    end
                    ST_ARGS: begin
                        state_q <= ST_ARGS;
                    end
                    ST_IGNORE: begin
                        state_q <= ST_IGNORE;
                    end
                    default: begin
                        state_q <= ST_IGNORE;
                    end
                endcase
            end
        end
    end

    // array prefetch; one request in flight, so stop requesting two short of full
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fetch_req_q  <= 1'b0;
            fetch_addr_q <= `SFE_ADDR_ZERO;
        end else begin
            if (state_q == ST_ADDR && sck_rise && bit_cnt_q == 5'd23 && !sel_n_q) begin
                fetch_addr_q <= addr_next[18:0] & mask;
                fetch_req_q  <= 1'b0;
            end else begin
                if (push) begin
                    fetch_addr_q <= (fetch_addr_q + 19'h00001) & mask;
                end
                fetch_req_q <= fetch_on_q && !sel_n_q &&
                               (fifo_level < `SFE_FIFO_DEPTH - 2) && !(fetch_req_q && !fetch_ack);
            end
        end
    end

    // serial output: change on sck fall, msb first
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            shift_out_q <= 8'h00;
            so_out_q    <= 1'b0;
            so_oe_q     <= 1'b0;
        end else if (sel_n_q || state_q != ST_DATA) begin
            so_oe_q  <= 1'b0;
            so_out_q <= 1'b0;
        end else if (sck_fall) begin
            so_oe_q <= 1'b1;
            if (bit_cnt_q == 5'h00) begin
                // an empty fifo means the array was too slow; zeros go out
                shift_out_q <= fifo_out_valid ? {fifo_out_data[6:0], 1'b0} : 8'h00;
                so_out_q    <= fifo_out_valid & fifo_out_data[7];
            end else begin
                shift_out_q <= {shift_out_q[6:0], 1'b0};
                so_out_q    <= shift_out_q[7];
            end
        end
    end
endmodule

// ==== sfe_defines.vh ====
// Purpose: shared constants of the serial flash command front end
// Assumes: included by bare name from the front end and its checker; the fifo does not include it
// Notes:   opcodes, decoded command classes, density codes and fifo shape
`ifndef SFE_DEFINES_VH
`define SFE_DEFINES_VH

// instruction codes
`define SFE_OP_READ            8'h03
`define SFE_OP_FAST_READ       8'h0b
`define SFE_OP_DUAL_IO_READ    8'hbb
`define SFE_OP_DUAL_OUT_READ   8'h3b
`define SFE_OP_QUAD_IO_READ    8'heb
`define SFE_OP_QUAD_OUT_READ   8'h6b
`define SFE_OP_PAGE_PROGRAM    8'h02
`define SFE_OP_QUAD_PP_A       8'h32
`define SFE_OP_QUAD_PP_B       8'h38
`define SFE_OP_ERASE_ALL_A     8'hc7
`define SFE_OP_ERASE_ALL_B     8'h60
`define SFE_OP_SUSPEND_A       8'h75
`define SFE_OP_SUSPEND_B       8'hb0
`define SFE_OP_RESUME_A        8'h7a
`define SFE_OP_RESUME_B        8'h30
`define SFE_OP_SLEEP_ENTER     8'hb9
`define SFE_OP_ID_WAKE         8'hab
`define SFE_OP_UNIQUE_ID       8'h4b
`define SFE_OP_STANDARD_ID     8'h9f
`define SFE_OP_MAKER_DEV_ID    8'h90
`define SFE_OP_WRITE_LATCH_SET 8'h06

// decoded command classes
`define SFE_CLS_W              5
`define SFE_CLS_NONE           5'h00
`define SFE_CLS_READ           5'h01
`define SFE_CLS_FAST_READ      5'h02
`define SFE_CLS_DUAL_IO_READ   5'h03
`define SFE_CLS_DUAL_OUT_READ  5'h04
`define SFE_CLS_QUAD_IO_READ   5'h05
`define SFE_CLS_QUAD_OUT_READ  5'h06
`define SFE_CLS_PAGE_PROGRAM   5'h07
`define SFE_CLS_QUAD_PP        5'h08
`define SFE_CLS_ERASE_ALL      5'h09
`define SFE_CLS_SUSPEND        5'h0a
`define SFE_CLS_RESUME         5'h0b
`define SFE_CLS_SLEEP_ENTER    5'h0c
`define SFE_CLS_ID_WAKE        5'h0d
`define SFE_CLS_UNIQUE_ID      5'h0e
`define SFE_CLS_STANDARD_ID    5'h0f
`define SFE_CLS_MAKER_DEV_ID   5'h10
`define SFE_CLS_WRITE_LATCH    5'h11

// density codes: decoded address width 19 down to 15 bits
`define SFE_DENS_4M            3'h0
`define SFE_DENS_2M            3'h1
`define SFE_DENS_1M            3'h2
`define SFE_DENS_512K          3'h3
`define SFE_DENS_256K          3'h4

// widths and counts
`define SFE_ADDR_BITS          24
`define SFE_ARRAY_AW           19
`define SFE_INSTR_BITS         8
`define SFE_FIFO_DEPTH         16
`define SFE_FIFO_AW            4
`define SFE_FIFO_W             8
`define SFE_ADDR_ZERO          19'h00000

`endif

// ==== sfe_fifo.v ====
// Purpose: byte fifo between the array fetch and the serial shifter
// Assumes: single clock, flush empties it in one cycle
// Notes:   level shows the fill so the producer can leave room for a beat in flight
module sfe_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             nrst,
    input  wire             flush,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0]      level
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;
    integer         i;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_q[i] <= {WIDTH{1'b0}};
            end
        end else if (flush) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q        <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ==== sfe_front_end_chk.sv ====
// Purpose: port-level checker of the serial command front end
// Assumes: sck phases of at least four sys_clk cycles, as the bench drives them
// Notes:   watches only top-level ports
`include "sfe_defines.vh"
module sfe_front_end_chk (
    input logic        sys_clk,
    input logic        nrst,
    input logic        sel_n,
    input logic        sck,
    input logic        si,
    input logic [2:0]  density_sel,
    input logic        write_in_progress,
    input logic        write_latch,
    input logic        quad_enable,
    input logic        fetch_ack,
    input logic [7:0]  fetch_data,
    input logic        so_out_q,
    input logic        so_oe_q,
    input logic        fetch_req_q,
    input logic [18:0] fetch_addr_q,
    input logic [7:0]  instr_q,
    input logic [4:0]  cmd_class_q,
    input logic        cmd_go_q,
    input logic        read_refused_q,
    input logic        quad_lines_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_go_pulse; cmd_go_q |=> !cmd_go_q; endproperty
    a_go_pulse: assert property (p_go_pulse) else $error("command pulse too long");
    property p_oe_off; sel_n [*4] |-> !so_oe_q; endproperty
    a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
    // data may only move while sck is low, so the host never samples a changing bit
    property p_so_fall; so_oe_q && $changed(so_out_q) |-> !sck; endproperty
    a_so_fall: assert property (p_so_fall) else $error("output changed outside low phase");
    property p_refuse; read_refused_q |-> write_in_progress && !cmd_go_q; endproperty
    a_refuse: assert property (p_refuse) else $error("refusal without busy");
    property p_refuse_quiet; read_refused_q |=> !fetch_req_q [*8]; endproperty
    a_refuse_quiet: assert property (p_refuse_quiet) else $error("fetch after refusal");
    property p_read_idle;
        cmd_go_q && cmd_class_q != 5'h00 && cmd_class_q <= 5'h06 |-> !write_in_progress;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read issued while busy");
    property p_erase_small; cmd_go_q && cmd_class_q == 5'h09 |-> density_sel < 3'h4; endproperty
    a_erase_small: assert property (p_erase_small) else $error("erase on smallest density");
    property p_latch; cmd_go_q && cmd_class_q inside {5'h07, 5'h08, 5'h09} |-> write_latch; endproperty
    a_latch: assert property (p_latch) else $error("write issued without latch");
    property p_mask;
        fetch_req_q && density_sel <= 3'h4 |-> (fetch_addr_q >> (5'd19 - {2'b00, density_sel})) == 19'h0;
    endproperty
    a_mask: assert property (p_mask) else $error("address beyond density");
    property p_fetch_inc;
        fetch_req_q && fetch_ack && !sel_n ##1 !sel_n |->
            fetch_addr_q == $past(fetch_addr_q) + 19'h1 || fetch_addr_q == 19'h0;
    endproperty
    a_fetch_inc: assert property (p_fetch_inc) else $error("fetch address not advanced");
    property p_quad; (quad_enable [*3] |-> quad_lines_q) and (!quad_enable [*3] |-> !quad_lines_q); endproperty
    a_quad: assert property (p_quad) else $error("quad lines not following enable");
endmodule
bind sfe_front_end sfe_front_end_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .sel_n(sel_n), .sck(sck), .si(si),
    .density_sel(density_sel), .write_in_progress(write_in_progress), .write_latch(write_latch),
    .quad_enable(quad_enable), .fetch_ack(fetch_ack), .fetch_data(fetch_data), .so_out_q(so_out_q),
    .so_oe_q(so_oe_q), .fetch_req_q(fetch_req_q), .fetch_addr_q(fetch_addr_q), .instr_q(instr_q),
    .cmd_class_q(cmd_class_q), .cmd_go_q(cmd_go_q), .read_refused_q(read_refused_q), .quad_lines_q(quad_lines_q));

// ==== sfe_spi_host_mdl.sv ====
// Purpose: mode 0 serial host driving select, clock and data
// Assumes: called from the bench, all changes on sys_clk falling edges
// Notes:   sck stands low outside frames; released si shows the inverse of its last bit
module sfe_spi_host_mdl (
    input  logic sys_clk,
    input  logic so_out_q,
    output logic sel_n,
    output logic sck,
    output logic si
);
    timeunit 1ns;
    timeprecision 100ps;
    // 8 sys_clk per bit is 25 MHz, under the normal read ceiling
    localparam int HALF = 4;
    initial begin
        sel_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic open_frame();
        wait_n(1);
        sel_n = 1'b0;
        wait_n(HALF);
    endtask
    task automatic close_frame();
        wait_n(HALF);
        sel_n = 1'b1;
        si = ~si;
        wait_n(2 * HALF);
    endtask
    // bits leave msb first; so is taken just before the rise that closes its bit
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            si = tx[i];
            wait_n(HALF);
            rx[i] = so_out_q;
            sck = 1'b1;
            wait_n(HALF);
            sck = 1'b0;
        end
    endtask
endmodule

// ==== test_serial_flash_cmd_front_end.sv ====
// Purpose: self-checking bench of the serial command front end
// Assumes: array answers the first cycle of a request, then misses one, so the fifo sees gaps
// Notes:   array bytes are a function of address, so wrap and masking show in the data
module test_serial_flash_cmd_front_end;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk, nrst, sel_n, sck, si, write_in_progress, write_latch, quad_enable, ack_en;
    logic        so_out_q, so_oe_q, fetch_req_q, cmd_go_q, read_refused_q, quad_lines_q, oe_seen;
    logic [2:0]  density_sel;
    logic [18:0] fetch_addr_q;
    logic [7:0]  instr_q, rx;
    logic [4:0]  cmd_class_q, last_cls;
    int          bad_count = 0, compares = 0, go_cnt = 0, ref_cnt = 0;
    localparam logic [7:0] OPS [20] = '{8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h75, 8'hb0, 8'h7a, 8'h30, 8'hb9,
                                        8'hab, 8'h4b, 8'h9f, 8'h90, 8'h02, 8'h32, 8'h38, 8'hc7, 8'h60, 8'h06};
    localparam logic [4:0] CLS [20] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0a, 5'h0a, 5'h0b, 5'h0b, 5'h0c,
                                        5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h07, 5'h08, 5'h08, 5'h09, 5'h09, 5'h11};
    function automatic logic [7:0] pat(input logic [18:0] a);
        return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]};
    endfunction
    wire         fetch_ack = fetch_req_q & ack_en;
    wire  [7:0]  fetch_data = pat(fetch_addr_q);
    sfe_front_end u_dut (.sys_clk(sys_clk), .nrst(nrst), .sel_n(sel_n), .sck(sck), .si(si),
        .density_sel(density_sel), .write_in_progress(write_in_progress), .write_latch(write_latch),
        .quad_enable(quad_enable), .fetch_ack(fetch_ack), .fetch_data(fetch_data), .so_out_q(so_out_q),
        .so_oe_q(so_oe_q), .fetch_req_q(fetch_req_q), .fetch_addr_q(fetch_addr_q), .instr_q(instr_q),
        .cmd_class_q(cmd_class_q), .cmd_go_q(cmd_go_q), .read_refused_q(read_refused_q),
        .quad_lines_q(quad_lines_q));
    sfe_spi_host_mdl u_host (.sys_clk(sys_clk), .so_out_q(so_out_q), .sel_n(sel_n), .sck(sck), .si(si));
    always @(posedge sys_clk) begin
        if (cmd_go_q === 1'b1) begin
            go_cnt++;
            last_cls = cmd_class_q;
        end
        if (read_refused_q === 1'b1) ref_cnt++;
        if (so_oe_q === 1'b1) oe_seen = 1'b1;
    end
    // the front end drops an unanswered request, so a fixed ack phase could starve it forever
    always @(negedge sys_clk) ack_en <= fetch_req_q ? ~ack_en : 1'b0;
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic rd_hdr(input logic [23:0] a);
        u_host.open_frame();
        u_host.xfer(8'h03, 8, rx);
        for (int i = 2; i >= 0; i--) u_host.xfer(a[8*i +: 8], 8, rx);
    endtask
    task automatic one_cmd(input logic [7:0] op, output int dg);
        int g0;
        g0 = go_cnt;
        u_host.open_frame();
        u_host.xfer(op, 8, rx);
        u_host.xfer(8'h00, 8, rx);
        u_host.close_frame();
        dg = go_cnt - g0;
    endtask
    // unused high address bits set, read runs over the top of every density
    task automatic t_wrap_density();
        logic [18:0] mask;
        int g0;
        for (int d = 0; d <= 4; d++) begin
            density_sel = d[2:0];
            mask = 19'h7ffff >> d;
            g0 = go_cnt;
            rd_hdr(24'hfffffe);
            check(go_cnt - g0, 1);
            check({instr_q, 3'h0, last_cls}, {8'h03, 3'h0, 5'h01});
            for (int k = 0; k < 3; k++) begin
                u_host.xfer(8'h5a ^ k[7:0], 8, rx);
                check(rx, pat((mask - 19'h1 + k[18:0]) & mask));
            end
            u_host.close_frame();
        end
        density_sel = 3'h0;
    endtask
    task automatic t_decode();
        int dg;
        write_latch = 1'b1;
        for (int i = 0; i < 20; i++) begin
            one_cmd(OPS[i], dg);
            check(dg, 1);
            check(last_cls, CLS[i]);
            check(instr_q, OPS[i]);
        end
    endtask
    task automatic t_refuse();
        int dg;
        int r0;
        write_latch = 1'b0;
        for (int i = 14; i < 19; i++) begin
            one_cmd(OPS[i], dg);
            check(dg, 0);
        end
        write_latch = 1'b1;
        density_sel = 3'h4;
        for (int i = 17; i < 19; i++) begin
            one_cmd(OPS[i], dg);
            check(dg, 0);
        end
        density_sel = 3'h0;
        oe_seen = 1'b0;
        one_cmd(8'hff, dg);
        check(dg, 0);
        write_in_progress = 1'b1;
        r0 = ref_cnt;
        one_cmd(8'h03, dg);
        check(dg, 0);
        for (int i = 0; i < 5; i++) begin
            one_cmd(OPS[i], dg);
            check(dg, 0);
        end
        check(ref_cnt - r0, 6);
        check(oe_seen, 0);
        write_in_progress = 1'b0;
    endtask
    // a cut in mid-byte must leave no stale fifo bytes for the next read
    task automatic t_abort();
        rd_hdr(24'h000100);
        u_host.xfer(8'h00, 3, rx);
        u_host.close_frame();
        check(so_oe_q, 0);
        rd_hdr(24'h000200);
        u_host.xfer(8'h00, 8, rx);
        check(rx, pat(19'h00200));
        u_host.close_frame();
    endtask
    task automatic t_quad();
        quad_enable = 1'b1;
        repeat (4) @(negedge sys_clk);
        check(quad_lines_q, 1);
        quad_enable = 1'b0;
        repeat (4) @(negedge sys_clk);
        check(quad_lines_q, 0);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        {nrst, write_in_progress, write_latch, quad_enable, ack_en, oe_seen} = 6'h00;
        density_sel = 3'h0;
        repeat (10) @(negedge sys_clk);
        check({so_oe_q, fetch_req_q, cmd_go_q, fetch_addr_q}, 24'h0);
        nrst = 1'b1;
        t_wrap_density();
        t_decode();
        t_refuse();
        t_abort();
        t_quad();
        print_verdict();
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        bad_count++;
        print_verdict();
    end
endmodule
